// [logic/wpd_top.sv]
// wide pulse modulator dac: special function registers, value transfer
// and port line selection. assumes a single-cycle sfr write and read
// strobe from the core, synchronous to mclk_i.
`timescale 1ns/1ps
`default_nettype none
`include "wpd_params.svh"

// Function
// - pulse period fixed, independent of value
// - top seven bits set base high time
// - base high time equals coarse times step
// - extend N of every 128 pulses one step
// - new value loads only on high-byte write
// - enable set drives port line from modulator
// - enable clear leaves port line to latch
// - high byte holds value bits 13 to 8
// - low byte bit 7 is coarse lsb
// - low bits 6 to 0 are extension count
// - high at d3, low at d2
module wpd_top #(
    parameter int PERIOD_CYCLES = `WPD_PERIOD_CYCLES // period length in clocks
) (
    input wire logic mclk_i,                    // core clock, 200 mhz
    input wire logic rst_b_i,                   // async reset, active low
    input wire logic ce_i,                      // clock enable
    input wire wpd_pkg::wpd_byte_t sfr_addr_i,  // sfr address
    input wire wpd_pkg::wpd_byte_t sfr_wdata_i, // sfr write data
    input wire logic sfr_wr_i,                  // sfr write strobe
    input wire logic sfr_rd_i,                  // sfr read strobe
    input wire logic port_latch_i,              // port register bit for line
    output logic sfr_sel_o,                     // read hit this block
    output wpd_pkg::wpd_byte_t sfr_rdata_o,     // sfr read data
    output logic pin_output_enable_o,           // modulator owns the line
    output logic port_two_line_zero_o           // port line level
);
    import wpd_pkg::*;

    wpd_mod_if mif ();

    wpd_byte_t low_reg;
    wpd_byte_t high_reg;
    wpd_value_t active_reg;
    wpd_byte_t rdata_reg;
    logic sel_reg;
    logic line_reg;
    logic wr_low;
    logic wr_high;

    function automatic wpd_byte_t read_mux(input wpd_byte_t a,
                                           input wpd_byte_t lo,
                                           input wpd_byte_t hi);
        wpd_byte_t r;
        r = 8'h00;
        if (a == `WPD_ADDR_LOW) begin
            r = lo;
        end else if (a == `WPD_ADDR_HIGH) begin
            r = hi | `WPD_UNUSED_MASK; // unused bit reads one
        end
        return r;
    endfunction

    // -----------------------------------------------------------------
    // address decode
    // -----------------------------------------------------------------
    assign wr_low = sfr_wr_i && (sfr_addr_i == `WPD_ADDR_LOW);
    assign wr_high = sfr_wr_i && (sfr_addr_i == `WPD_ADDR_HIGH);

    // -----------------------------------------------------------------
    // holding registers
    // -----------------------------------------------------------------
    // the low byte alone never reaches the modulator; software is
    // expected to write it first and then the high byte
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            low_reg <= `WPD_LOW_RST;
        end else if (ce_i && wr_low) begin
            low_reg <= sfr_wdata_i;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            high_reg <= `WPD_HIGH_RST;
        end else if (ce_i && wr_high) begin
            high_reg <= sfr_wdata_i | `WPD_UNUSED_MASK;
        end
    end

    // the high write carries the low byte in the same cycle, so a low
    // write landing together is not possible on one strobe
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            active_reg <= 14'h0000;
        end else if (ce_i && wr_high) begin
            active_reg <= {sfr_wdata_i[`WPD_HIGH_VAL_MSB:0], low_reg};
        end
    end

    assign mif.value = active_reg;

    // -----------------------------------------------------------------
    // read path, one cycle after the strobe
    // -----------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_reg <= 8'h00;
            sel_reg <= 1'b0;
        end else if (ce_i) begin
            rdata_reg <= sfr_rd_i ?
                read_mux(sfr_addr_i, low_reg, high_reg) : 8'h00;
            sel_reg <= sfr_rd_i && ((sfr_addr_i == `WPD_ADDR_LOW) ||
                                    (sfr_addr_i == `WPD_ADDR_HIGH));
        end
    end

    // -----------------------------------------------------------------
    // port line selection
    // -----------------------------------------------------------------
    // registered so the pin never glitches while the enable changes
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            line_reg <= 1'b1;
        end else if (ce_i) begin
            if (high_reg[`WPD_PWE_BIT]) begin
                line_reg <= mif.pwm;
            end else begin
                line_reg <= port_latch_i;
            end
        end
    end

    assign sfr_rdata_o = rdata_reg;
    assign sfr_sel_o = sel_reg;
    assign pin_output_enable_o = high_reg[`WPD_PWE_BIT];
    assign port_two_line_zero_o = line_reg;

    wpd_mod_core #(
        .PERIOD_CYCLES(PERIOD_CYCLES)
    ) u_core (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .mif(mif)
    );

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);

    chk_value_hold: assert property (
        !(ce_i && wr_high) |=> $stable(active_reg))
        else $error("active value changed without high-byte write");
    chk_value_map: assert property (
        ce_i && wr_high |=>
        active_reg == {$past(sfr_wdata_i[5:0]), $past(low_reg)})
        else $error("value bits mapped wrongly");
    chk_low_fields: assert property (
        ce_i && wr_low ##1 ce_i && wr_high |=>
        active_reg[6:0] == $past(sfr_wdata_i[6:0], 2))
        else $error("extension count not taken from low byte");
    chk_high_readback: assert property (
        ce_i && wr_high ##1 ce_i && sfr_rd_i
        && sfr_addr_i == `WPD_ADDR_HIGH |=>
        sfr_rdata_o == ($past(sfr_wdata_i, 2) | 8'h40))
        else $error("high byte readback wrong");
    chk_decode_only: assert property (
        ce_i && sfr_wr_i && sfr_addr_i != 8'hd2
        && sfr_addr_i != 8'hd3 |=> $stable(low_reg) && $stable(high_reg))
        else $error("write to foreign address changed a register");
    chk_pin_pwm: assert property (
        ce_i && high_reg[7] |=>
        port_two_line_zero_o == $past(mif.pwm))
        else $error("line not driven by modulator when enabled");
    chk_pin_latch: assert property (
        ce_i && !high_reg[7] |=>
        port_two_line_zero_o == $past(port_latch_i))
        else $error("line not following port latch when disabled");
endmodule

`default_nettype wire

// [logic/wpd_params.svh]
// constants for the wide pulse modulator dac: addresses, fields, resets
// and timing; included by wpd_top and wpd_mod_core, defines only.
`ifndef WPD_PARAMS_SVH
`define WPD_PARAMS_SVH

// -----------------------------------------------------------------
// special function register addresses
// -----------------------------------------------------------------
`define WPD_ADDR_LOW 8'hd2
`define WPD_ADDR_HIGH 8'hd3

// -----------------------------------------------------------------
// field positions and reset values
// -----------------------------------------------------------------
`define WPD_PWE_BIT 7
`define WPD_UNUSED_BIT 6
`define WPD_HIGH_VAL_MSB 5
`define WPD_LOW_RST 8'h00
`define WPD_HIGH_RST 8'h40
`define WPD_UNUSED_MASK 8'h40

// -----------------------------------------------------------------
// timing: figures in picoseconds, counts derived from the clock
// -----------------------------------------------------------------
`define WPD_CLK_PERIOD_PS 5000
`define WPD_PERIOD_PS 42660
`define WPD_STEP_PS 330
`define WPD_STEPS_PER_PERIOD 128
`define WPD_PERIOD_CYCLES (`WPD_PERIOD_PS * 200 / 1000)
`define WPD_STEP_CYCLES(p) ((p) / `WPD_STEPS_PER_PERIOD)

`endif

// [logic/wpd_pkg.sv]
// types shared by the wide pulse modulator dac modules.
// assumes nothing beyond the params header.
package wpd_pkg;
    typedef logic [7:0] wpd_byte_t;
    typedef logic [13:0] wpd_value_t;
    typedef logic [6:0] wpd_field_t;
    typedef logic [7:0] wpd_presc_t;
endpackage

// [logic/wpd_mod_if.sv]
// carrier between the register side and the modulator core.
// assumes both ends share mclk_i.
`timescale 1ns/1ps
`default_nettype none

interface wpd_mod_if;
    wpd_pkg::wpd_value_t value;
    logic pwm;
    modport ctl (output value, input pwm);
    modport core (input value, output pwm);
endinterface

`default_nettype wire

// [logic/wpd_mod_core.sv]
// modulator core: prescaler, step and frame counters, pulse output.
// assumes a synchronous clock enable and the value held by the register side.
`timescale 1ns/1ps
`default_nettype none
`include "wpd_params.svh"

module wpd_mod_core #(
    parameter int PERIOD_CYCLES = `WPD_PERIOD_CYCLES
) (
    input wire logic mclk_i,      // core clock
    input wire logic rst_b_i,     // async reset, active low
    input wire logic ce_i,        // clock enable
    wpd_mod_if.core mif           // value in, pulse out
);
    import wpd_pkg::*;

    localparam wpd_presc_t STEP_C =
        wpd_presc_t'(`WPD_STEP_CYCLES(PERIOD_CYCLES));

    wpd_presc_t presc_reg;
    wpd_field_t step_reg;
    wpd_field_t frame_reg;
    wpd_value_t cur_reg;
    logic pwm_reg;
    logic step_tick;
    logic period_end;
    logic ext;
    logic [7:0] width;

    function automatic wpd_field_t bitrev(input wpd_field_t v);
        wpd_field_t r;
        r = '0;
        for (int i = 0; i < 7; i++) begin
            r[i] = v[6 - i];
        end
        return r;
    endfunction

    assign step_tick = (presc_reg == STEP_C - 8'h01);
    assign period_end = step_tick && (step_reg == 7'h7f);
    // reversed frame count spreads the extended periods evenly
    assign ext = (bitrev(frame_reg) < cur_reg[6:0]);
    assign width = {1'b0, cur_reg[13:7]} + {7'h00, ext};

    // -----------------------------------------------------------------
    // step prescaler
    // -----------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            presc_reg <= 8'h00;
        end else if (ce_i) begin
            presc_reg <= step_tick ? 8'h00 : presc_reg + 8'h01;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            step_reg <= 7'h00;
        end else if (ce_i && step_tick) begin
            step_reg <= step_reg + 7'h01;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            frame_reg <= 7'h00;
        end else if (ce_i && period_end) begin
            frame_reg <= frame_reg + 7'h01;
        end
    end

    // new value only at a period boundary, so no pulse is cut short
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cur_reg <= 14'h0000;
        end else if (ce_i && period_end) begin
            cur_reg <= mif.value;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pwm_reg <= 1'b0;
        end else if (ce_i) begin
            pwm_reg <= ({1'b0, step_reg} < width);
        end
    end

    assign mif.pwm = pwm_reg;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    logic [7:0] ext_seen;
    logic cur_moved;
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ext_seen <= 8'h00;
            cur_moved <= 1'b0;
        end else if (ce_i && period_end) begin
            if (frame_reg == 7'h7f) begin
                ext_seen <= 8'h00;
                cur_moved <= 1'b0;
            end else begin
                ext_seen <= ext_seen + {7'h00, ext};
                cur_moved <= cur_moved || (mif.value != cur_reg);
            end
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);

    chk_presc_range: assert property (presc_reg < STEP_C)
        else $error("prescaler out of range");
    chk_period_wrap: assert property (
        ce_i && period_end |=> step_reg == 7'h00)
        else $error("period did not wrap after 128 steps");
    chk_zero_width: assert property (
        ce_i && cur_reg == 14'h0000 |=> !pwm_reg)
        else $error("zero value produced a pulse");
    chk_pulse_width: assert property (
        pwm_reg |-> {1'b0, $past(step_reg)} < $past(width))
        else $error("pulse high beyond programmed width");
    chk_ext_count: assert property (
        ce_i && period_end && frame_reg == 7'h7f && !cur_moved
        && mif.value == cur_reg |->
        ext_seen + {7'h00, ext} == {1'b0, cur_reg[6:0]})
        else $error("wrong number of extended pulses in frame");
endmodule

`default_nettype wire

// [test/wpd_filter_model.sv]
// far-side model: the analogue filter watching the port line.
// assumes the line is sampled on mclk_i; measures each pulse in clocks.
`timescale 1ns/1ps
`default_nettype none

module wpd_filter_model (
    input wire logic mclk_i,          // core clock
    input wire logic rst_b_i,         // async reset, active low
    input wire logic line_i,          // port line level
    output logic done_o,              // one cycle at each falling edge
    output logic [15:0] width_o,      // high clocks of last pulse
    output logic [15:0] period_o      // clocks between last two rises
);
    logic prev_reg;
    logic [15:0] hi_reg;
    logic [15:0] since_reg;

    // -------------------------------------------------------------
    // pulse measurement
    // -------------------------------------------------------------
    // prev resets high because the line idles high, so no false rise
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prev_reg <= 1'b1;
            hi_reg <= 16'h0000;
            since_reg <= 16'h0000;
            done_o <= 1'b0;
            width_o <= 16'h0000;
            period_o <= 16'h0000;
        end else begin
            prev_reg <= line_i;
            done_o <= 1'b0;
            since_reg <= since_reg + 16'h0001;
            if (line_i) begin
                hi_reg <= hi_reg + 16'h0001;
            end
            if (line_i && !prev_reg) begin
                period_o <= since_reg;
                since_reg <= 16'h0001;
                hi_reg <= 16'h0001;
            end
            if (!line_i && prev_reg) begin
                width_o <= hi_reg;
                done_o <= 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

// [test/tb_fourteen_bit_pwm_dac.sv]
// testbench for the wide pulse modulator dac top.
// assumes a short period parameter (256 clocks, step of 2 clocks).
`timescale 1ns/1ps
`default_nettype none

module tb_fourteen_bit_pwm_dac;
    import wpd_pkg::*;
    localparam int PC = 256;
    localparam int STEP = PC / 128;
    logic mclk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic ce_i = 1'b1;
    logic sfr_wr_i = 1'b0;
    logic sfr_rd_i = 1'b0;
    logic port_latch_i = 1'b0;
    wpd_byte_t sfr_addr_i = 8'h00;
    wpd_byte_t sfr_wdata_i = 8'h00;
    wpd_byte_t rdata, d;
    logic sel, oe, line, done, s;
    logic [15:0] width, period, w;
    int fails = 0;
    int tests_run = 0;
    int cyc = 0;

    wpd_top #(.PERIOD_CYCLES(PC)) dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
        .ce_i(ce_i), .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i),
        .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
        .port_latch_i(port_latch_i), .sfr_sel_o(sel), .sfr_rdata_o(rdata),
        .pin_output_enable_o(oe), .port_two_line_zero_o(line));
    wpd_filter_model filt (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
        .line_i(line), .done_o(done), .width_o(width), .period_o(period));

    always #2.5 mclk_i = ~mclk_i;

    // -------------------------------------------------------------
    // tasks
    // -------------------------------------------------------------
    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // budget: two 128-period frames plus about 95 more periods
    always @(posedge mclk_i) begin
        cyc = cyc + 1;
        if (cyc == 90000) begin
            fails = fails + 1;
            $display("[FAIL] %0t run did not finish", $time);
            results();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input wpd_byte_t a, input wpd_byte_t v);
        @(negedge mclk_i);
        sfr_addr_i = a;
        sfr_wdata_i = v;
        sfr_wr_i = 1'b1;
        @(negedge mclk_i);
        sfr_wr_i = 1'b0;
    endtask

    // low then high on back-to-back strobes, then read the high byte
    task automatic wr_pair(input wpd_byte_t lo, input wpd_byte_t hi);
        @(negedge mclk_i);
        sfr_addr_i = 8'hd2;
        sfr_wdata_i = lo;
        sfr_wr_i = 1'b1;
        @(negedge mclk_i);
        sfr_addr_i = 8'hd3;
        sfr_wdata_i = hi;
        @(negedge mclk_i);
        sfr_wr_i = 1'b0;
        sfr_rd_i = 1'b1;
        @(negedge mclk_i);
        sfr_rd_i = 1'b0;
        d = rdata;
        s = sel;
    endtask

    // read answer is registered; allow it two extra cycles at most
    task automatic rd_reg(input wpd_byte_t a);
        int n;
        n = 0;
        @(negedge mclk_i);
        sfr_addr_i = a;
        sfr_rd_i = 1'b1;
        @(negedge mclk_i);
        sfr_rd_i = 1'b0;
        while (sel !== 1'b1 && n < 2) begin
            @(negedge mclk_i);
            n = n + 1;
        end
        d = rdata;
        s = sel;
    endtask

    task automatic pulses(input int k);
        int n;
        repeat (k) begin
            n = 0;
            do begin
                @(negedge mclk_i);
                n = n + 1;
            end while (done !== 1'b1 && n < 600);
            w = (done === 1'b1) ? width : 16'hxxxx;
        end
    endtask

    task automatic latch_follow;
        for (int i = 0; i < 2; i++) begin
            @(negedge mclk_i);
            port_latch_i = i[0];
            repeat (2) @(negedge mclk_i);
            chk(line, i[0]);
        end
        chk(oe, 1'b0);
    endtask

    // one 128-period frame: count stretched pulses and adjacent pairs
    task automatic frame(input int cnt);
        int ext, adj, base;
        logic last;
        ext = 0;
        adj = 0;
        base = 0;
        last = 1'b0;
        wr_pair(8'(cnt), 8'h81);
        chk(d, 8'hc1);
        pulses(2);
        repeat (128) begin
            pulses(1);
            if (w === 16'(3 * STEP)) begin
                ext = ext + 1;
                if (last) adj = adj + 1;
            end
            if (w === 16'(2 * STEP)) base = base + 1;
            last = (w === 16'(3 * STEP));
        end
        chk(16'(ext), 16'(cnt));
        chk(16'(base), 16'(128 - cnt));
        chk(16'(adj), 16'h0000);
        $display("frame with count %0d done", cnt);
    endtask

    // -------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------
    initial begin
        repeat (3) @(negedge mclk_i);
        rst_b_i = 1'b1;
        rd_reg(8'hd2);
        chk({s, d}, 16'h0100);
        rd_reg(8'hd3);
        chk({s, d}, 16'h0140);
        rd_reg(8'hd4);
        chk({s, d}, 16'h0000);
        latch_follow();
        $display("reset and register map test done");
        wr_reg(8'hd2, 8'h80);
        rd_reg(8'hd2);
        chk(d, 8'h80);
        latch_follow();
        wr_pair(8'h80, 8'h85);
        chk(d, 8'hc5);
        chk(oe, 1'b1);
        pulses(3);
        chk(w, 16'(11 * STEP));
        chk(period, 16'(PC));
        wr_reg(8'hd2, 8'h00);
        pulses(3);
        chk(w, 16'(11 * STEP));
        wr_reg(8'hd3, 8'hbf);
        pulses(3);
        chk(w, 16'(126 * STEP));
        chk(period, 16'(PC));
        wr_reg(8'hd3, 8'h81);
        pulses(3);
        chk(w, 16'(2 * STEP));
        $display("coarse width test done");
        frame(64);
        frame(1);
        wr_reg(8'hd3, 8'h01);
        latch_follow();
        $display("enable release test done");
        results();
    end
endmodule

`default_nettype wire
